// [trts_core.sv]
/*
 Token rotation and holding timers, claim and beacon recovery and service
 opportunity start and end for a ring engine, with an APB register slave.
 Assumes ring event inputs are one-cycle pulses synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module trts_core #(
    parameter int TW = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic token_rcvd,
    input wire logic token_rstr,
    input wire logic tvx_expired,
    input wire logic claim_higher,
    input wire logic my_claim,
    input wire logic my_beacon,
    input wire logic beacon_rcvd,
    input wire logic mac_frame_rcvd,
    input wire logic req_valid,
    input wire trts_pkg::trts_class_e req_class,
    input wire trts_pkg::trts_cap_e req_capture,
    input wire logic req_issue_rstr,
    input wire logic req_tht_en,
    input wire logic req_done,
    input wire logic data_ready,
    input wire logic frame_active,
    input wire logic frame_done,
    output logic svc_start,
    output logic token_issue,
    output logic token_issue_rstr,
    output trts_pkg::trts_mode_e tx_mode,
    output logic ring_op,
    output logic late_flag,
    output logic recovery_req
);
    import trts_pkg::*;

    initial
    begin
        if (TW < 8 || TW > 32)
            $error("trts_core: TW must be 8 to 32");
    end

    typedef struct packed {
        trts_state_e st;
        trts_mode_e mode;
        logic [TW-1:0] rotation_timer;
        logic [TW-1:0] holding_timer;
        logic [TW-1:0] negotiated_target_value;
        logic [TW-1:0] maximum_time_value;
        logic [TW-1:0] requested_rotation_time;
        logic [TW-1:0] async_priority_threshold;
        logic [3:0] tick_cnt;
        logic [5:0] pre_cnt;
        logic [31:0] prdata;
        logic late, ring_op, rec_pend, rec_req, inhr, ipo, bcnr, macr, last_nr;
        logic cap_rstr, tht_en, apri, imm, svc_start, tok_issue, tok_rstr, pready, pslverr;
    } trts_st_s;

    trts_st_s r;
    trts_st_s next_r;
    logic tick, trt_exp, late_soon, tht_exp, wr, mrst_w, fbcn_w, ok, hit;
    logic [31:0] rd;

    // ****************************************
    // Decode and timer flags
    // ****************************************
    // The late test looks one count ahead so a token due to turn late is not used.
    assign tick = r.tick_cnt == TICK_LAST;
    assign trt_exp = tick && (r.rotation_timer == '1);
    assign late_soon = r.late || (r.rotation_timer == '1);
    assign tht_exp = r.holding_timer == '1;
    assign wr = psel && penable && pwrite && r.pready;
    assign mrst_w = wr && paddr == A_CTRL && pwdata[C_MRST];
    assign fbcn_w = wr && paddr == A_CTRL && pwdata[C_FBCN];

    // Capture criteria for a received token while the ring is operational.
    always_comb
    begin
        ok = 1'b0;
        unique case (req_class)
            CL_SYNC: ok = !r.bcnr;
            CL_ASYNC: ok = !late_soon && ((req_capture == CP_NRSTR && !token_rstr
                           && (!req_issue_rstr || (r.last_nr && !r.macr)))
                           || (req_capture == CP_RSTR && token_rstr && !r.macr));
            CL_APRI: ok = !late_soon && req_capture == CP_NRSTR && !token_rstr && r.holding_timer < r.async_priority_threshold;
            CL_IMM: ok = 1'b0;
        endcase
        ok = ok && req_valid;
    end

    // Read mux; unmapped addresses answer with an error.
    always_comb
    begin
        hit = 1'b1;
        rd = 32'h0000_0000;
        unique case (paddr)
            A_CTRL: rd = {29'h0, r.ipo, r.inhr, 1'b0};
            A_NEGOTIATED_TARGET_VALUE: rd = 32'(r.negotiated_target_value);
            A_MAXIMUM_TIME_VALUE: rd = 32'(r.maximum_time_value);
            A_REQUESTED_ROTATION_TIME: rd = 32'(r.requested_rotation_time);
            A_ASYNC_PRIORITY_THRESHOLD: rd = 32'(r.async_priority_threshold);
            A_STAT: rd = {24'h000000, r.st, r.macr, r.bcnr, r.rec_pend, r.late, r.ring_op};
            A_TRT: rd = 32'(r.rotation_timer);
            A_THT: rd = 32'(r.holding_timer);
            default: hit = 1'b0;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        next_r = r;
        next_r.svc_start = 1'b0;
        next_r.tok_issue = 1'b0;
        next_r.rec_req = 1'b0;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        next_r.tick_cnt = tick ? 4'h0 : r.tick_cnt + 4'h1;
        if (tick)
        begin
            next_r.rotation_timer = r.rotation_timer + 1'b1;
            if (r.st == ST_SERVE && r.tht_en && !tht_exp)
                next_r.holding_timer = r.holding_timer + 1'b1;
            if (r.rec_pend)
            begin
                // Deferred by one byte so slower stations expire first.
                next_r.rec_pend = 1'b0;
                next_r.rec_req = 1'b1;
                next_r.st = ST_CLAIM;
                next_r.ring_op = 1'b0;
            end
        end
        if (trt_exp)
        begin
            if (!r.ring_op)
            begin
                next_r.rotation_timer = r.maximum_time_value;
                if (r.st == ST_CLAIM)
                    next_r.st = ST_BEACON;
            end
            else if (!r.late)
            begin
                next_r.late = 1'b1;
                next_r.rotation_timer = r.negotiated_target_value;
            end
            else
            begin
                next_r.rotation_timer = r.maximum_time_value;
                next_r.rec_pend = !r.inhr;
            end
        end
        if (tvx_expired)
        begin
            next_r.st = ST_CLAIM;
            next_r.ring_op = 1'b0;
        end
        // Ring state machine.
        unique case (r.st)
            ST_LISTEN:
            begin
            end
            ST_CLAIM:
            begin
                if (claim_higher)
                    next_r.st = ST_LISTEN;
                else if (my_claim)
                begin
                    next_r.st = ST_OPER;
                    next_r.ring_op = 1'b1;
                    next_r.late = 1'b0;
                    next_r.negotiated_target_value = r.requested_rotation_time;
                    next_r.rotation_timer = r.requested_rotation_time;
                    next_r.tok_issue = 1'b1;
                    next_r.tok_rstr = 1'b0;
                    next_r.last_nr = 1'b1;
                end
            end
            ST_BEACON:
            begin
                if (my_beacon)
                    next_r.st = ST_CLAIM;
            end
            ST_OPER:
            begin
                if (token_rcvd && !trt_exp)
                begin
                    if (!r.late)
                        next_r.rotation_timer = r.negotiated_target_value;
                    else
                        next_r.late = 1'b0;
                    if (ok)
                    begin
                        next_r.st = ST_SERVE;
                        next_r.svc_start = 1'b1;
                        next_r.cap_rstr = token_rstr;
                        next_r.tht_en = req_tht_en && req_class != CL_SYNC;
                        next_r.apri = req_class == CL_APRI;
                        next_r.pre_cnt = 6'h00;
                    end
                end
            end
            ST_SERVE:
            begin
                if (frame_active)
                    next_r.pre_cnt = 6'h00;
                else if (tick && r.pre_cnt != 6'h3F)
                    next_r.pre_cnt = r.pre_cnt + 6'h01;
                if (frame_done && (req_done || !req_valid || (r.tht_en && tht_exp)
                    || (r.apri && !(r.holding_timer < r.async_priority_threshold))))
                begin
                    next_r.st = ST_OPER;
                    next_r.tok_issue = 1'b1;
                    next_r.tok_rstr = req_done ? req_issue_rstr : r.cap_rstr;
                    next_r.last_nr = !(req_done ? req_issue_rstr : r.cap_rstr);
                end
            end
        endcase
        // Holding timer shadows the rotation timer whenever no token is held.
        if (next_r.st != ST_SERVE && r.st != ST_SERVE)
            next_r.holding_timer = next_r.rotation_timer;
        // Immediate service from claim or beacon.
        next_r.imm = req_valid && req_class == CL_IMM && req_capture == CP_NONE
                     && (next_r.st == ST_CLAIM || next_r.st == ST_BEACON);
        if (next_r.imm && !r.imm)
            next_r.svc_start = 1'b1;
        // Register bus.
        if (psel && !penable)
        begin
            next_r.pready = 1'b1;
            next_r.prdata = rd;
            next_r.pslverr = !hit || (pwrite && (paddr == A_STAT || paddr == A_TRT || paddr == A_THT));
        end
        if (wr)
        begin
            unique case (paddr)
                A_CTRL:
                begin
                    next_r.inhr = pwdata[C_INHR];
                    next_r.ipo = pwdata[C_IPO];
                end
                A_NEGOTIATED_TARGET_VALUE: next_r.negotiated_target_value = pwdata[TW-1:0];
                A_MAXIMUM_TIME_VALUE: next_r.maximum_time_value = pwdata[TW-1:0];
                A_REQUESTED_ROTATION_TIME: next_r.requested_rotation_time = pwdata[TW-1:0];
                A_ASYNC_PRIORITY_THRESHOLD: next_r.async_priority_threshold = pwdata[TW-1:0];
                default:
                begin
                end
            endcase
        end
        // Status bits: a new event wins over a clear in the same cycle.
        next_r.bcnr = (r.bcnr && !(wr && paddr == A_CTRL && pwdata[C_CLRB])) || beacon_rcvd;
        next_r.macr = (r.macr && !(wr && paddr == A_CTRL && pwdata[C_CLRM])) || mac_frame_rcvd;
        if (fbcn_w)
        begin
            next_r.st = ST_BEACON;
            next_r.ring_op = 1'b0;
        end
        if (mrst_w)
        begin
            next_r.st = ST_LISTEN;
            next_r.ring_op = 1'b0;
            next_r.late = 1'b0;
            next_r.rec_pend = 1'b0;
            next_r.imm = 1'b0;
            next_r.rotation_timer = r.maximum_time_value;
            next_r.holding_timer = r.maximum_time_value;
        end
        // Transmit choice; in service without data and with ipo clear, a void keeps remote valid-transmission timers alive.
        unique case (next_r.st)
            ST_CLAIM: next_r.mode = (next_r.imm && data_ready) ? MD_DATA : MD_CLAIM;
            ST_BEACON: next_r.mode = (next_r.imm && data_ready) ? MD_DATA : MD_BEACON;
            ST_SERVE: next_r.mode = data_ready ? MD_DATA : (r.ipo ? MD_REPEAT : MD_VOID);
            default: next_r.mode = MD_REPEAT;
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.negotiated_target_value <= NEGOTIATED_TARGET_VALUE_RST[TW-1:0];
            r.maximum_time_value <= MAXIMUM_TIME_VALUE_RST[TW-1:0];
            r.requested_rotation_time <= REQUESTED_ROTATION_TIME_RST[TW-1:0];
            r.async_priority_threshold <= ASYNC_PRIORITY_THRESHOLD_RST[TW-1:0];
            r.rotation_timer <= MAXIMUM_TIME_VALUE_RST[TW-1:0];
            r.holding_timer <= MAXIMUM_TIME_VALUE_RST[TW-1:0];
            r.last_nr <= 1'b1;
        end
        else
            r <= next_r;
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign svc_start = r.svc_start;
    assign token_issue = r.tok_issue;
    assign token_issue_rstr = r.tok_rstr;
    assign tx_mode = r.mode;
    assign ring_op = r.ring_op;
    assign late_flag = r.late;
    assign recovery_req = r.rec_req;

    // ****************************************
    // Assertions
    // ****************************************
    localparam int RQ_MAX = TICK_CYC + 1;
    logic quiet;
    logic [6:0] idle_cnt;
    assign quiet = !mrst_w && !fbcn_w && !tvx_expired && !r.rec_pend;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            idle_cnt <= 7'h00;
        else if (r.st == ST_SERVE && r.mode == MD_REPEAT)
            idle_cnt <= idle_cnt + 7'h01;
        else
            idle_cnt <= 7'h00;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_late_exp;
        r.ring_op && trt_exp && r.late && !r.inhr && quiet;
    endsequence
    sequence s_recover;
        (r.rotation_timer == r.maximum_time_value) ##[0:RQ_MAX] r.rec_req;
    endsequence

    AST_COUNT: assert property (r.st == ST_OPER && tick && !trt_exp && !token_rcvd && quiet
        |=> r.rotation_timer == $past(r.rotation_timer) + 1'b1) else $error("rotation timer did not advance");
    AST_EARLY_EXP: assert property (r.ring_op && trt_exp && !r.late && quiet
        |=> r.late && r.rotation_timer == $past(r.negotiated_target_value)) else $error("early expiry mishandled");
    AST_RECOVER: assert property (s_late_exp |=> s_recover) else $error("no recovery after late expiry");
    AST_REC_DELAY: assert property (s_late_exp |=> !r.rec_req) else $error("recovery not deferred");
    AST_LATE_TOK: assert property (r.st == ST_OPER && token_rcvd && r.late && !trt_exp && quiet
        |=> !r.late && r.rotation_timer == $past(r.rotation_timer) + 1'b1) else $error("late token mishandled");
    AST_CLAIM_WIN: assert property (r.st == ST_CLAIM && my_claim && !claim_higher && !trt_exp && quiet
        |=> r.ring_op && r.tok_issue && r.negotiated_target_value == $past(r.requested_rotation_time)) else $error("own claim not honoured");
    AST_NO_SYNC: assert property (r.st == ST_OPER && token_rcvd && req_class == CL_SYNC && r.bcnr
        |=> !r.svc_start) else $error("sync served after beacon");
    AST_NO_RSTR: assert property (r.st == ST_OPER && token_rcvd && req_capture == CP_RSTR && r.macr
        |=> !r.svc_start) else $error("restricted served after MAC frame");
    AST_THT_HOLD: assert property (r.st == ST_SERVE && $past(r.st) == ST_SERVE && !r.tht_en && !mrst_w
        |=> $stable(r.holding_timer)) else $error("holding timer moved while disabled");
    AST_PREAMBLE: assert property (!r.ipo |-> idle_cnt <= 7'(PRE_MAX)) else $error("preamble too long");
    AST_BEACON: assert property (r.st == ST_CLAIM && trt_exp && !my_claim && !claim_higher && quiet
        |=> r.st == ST_BEACON) else $error("claim timeout did not beacon");
endmodule
`default_nettype wire

// [trts_pkg.sv]
/*
 Constants, register map and types for the token timing and service block.
 Assumes a 10 MHz pclk and a 32-bit APB register bus.
*/
`default_nettype none
package trts_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_NS = 100;
    localparam int TICK_NS = 80;
    localparam int TICK_RAW = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_CYC = (TICK_RAW < 1) ? 1 : TICK_RAW;
    localparam logic [3:0] TICK_LAST = 4'(TICK_CYC - 1);
    localparam logic [5:0] PRE_MAX = 6'h28;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_NEGOTIATED_TARGET_VALUE = 8'h04;
    localparam logic [7:0] A_MAXIMUM_TIME_VALUE = 8'h08;
    localparam logic [7:0] A_REQUESTED_ROTATION_TIME = 8'h0C;
    localparam logic [7:0] A_ASYNC_PRIORITY_THRESHOLD = 8'h10;
    localparam logic [7:0] A_STAT = 8'h14;
    localparam logic [7:0] A_TRT = 8'h18;
    localparam logic [7:0] A_THT = 8'h1C;
    localparam int C_MRST = 0;
    localparam int C_INHR = 1;
    localparam int C_IPO = 2;
    localparam int C_FBCN = 3;
    localparam int C_CLRB = 4;
    localparam int C_CLRM = 5;
    localparam logic [31:0] NEGOTIATED_TARGET_VALUE_RST = 32'hFFFF_F000;
    localparam logic [31:0] MAXIMUM_TIME_VALUE_RST = 32'hFFFF_0000;
    localparam logic [31:0] REQUESTED_ROTATION_TIME_RST = 32'hFFFF_F000;
    localparam logic [31:0] ASYNC_PRIORITY_THRESHOLD_RST = 32'hFFFF_F800;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {ST_LISTEN = 3'b000, ST_CLAIM = 3'b001, ST_BEACON = 3'b010,
                              ST_OPER = 3'b011, ST_SERVE = 3'b100} trts_state_e;
    typedef enum logic [1:0] {CL_SYNC = 2'b00, CL_ASYNC = 2'b01, CL_APRI = 2'b10,
                              CL_IMM = 2'b11} trts_class_e;
    typedef enum logic [1:0] {CP_NRSTR = 2'b00, CP_RSTR = 2'b01, CP_ANY = 2'b10,
                              CP_NONE = 2'b11} trts_cap_e;
    typedef enum logic [2:0] {MD_REPEAT = 3'b000, MD_CLAIM = 3'b001, MD_BEACON = 3'b010,
                              MD_DATA = 3'b011, MD_VOID = 3'b100} trts_mode_e;
endpackage
`default_nettype wire

// [trts_ring_model.sv]
/*
 Behavioural model of the other ring stations as seen through the physical layer.
 Assumes a single bench process calls ev() and that events are one cycle long.
*/
`timescale 1ns/1ps
`default_nettype none
module trts_ring_model (
    input wire logic pclk,
    output logic token_rcvd,
    output logic token_rstr,
    output logic tvx_expired,
    output logic claim_higher,
    output logic my_claim,
    output logic my_beacon,
    output logic beacon_rcvd,
    output logic mac_frame_rcvd,
    output logic frame_done
);
    logic [7:0] ev_q = 8'h00;
    logic rstr_q = 1'b0;

    // One bit per kind of ring event; every event line idles low between events, the class line at the inverse.
    assign {frame_done, mac_frame_rcvd, beacon_rcvd, my_beacon} = ev_q[7:4];
    assign {my_claim, claim_higher, tvx_expired, token_rcvd} = ev_q[3:0];
    assign token_rstr = rstr_q;

    // Raises event k for exactly one cycle, launched just after a rising edge.
    task automatic ev(input int k, input logic r);
        @(posedge pclk);
        ev_q <= 8'(8'h01 << k);
        rstr_q <= r; // The token class stands only beside the token itself.
        @(posedge pclk);
        ev_q <= 8'h00;
        rstr_q <= ~r; // A released class line shows the inverse, so a stale value cannot pass.
    endtask
endmodule
`default_nettype wire

// [trts_core_tb_top.sv]
/*
 Self-checking bench for trts_core: register table, service rows, recovery paths.
 Assumes the ring model beside it and the zero-wait APB slave of the core.
*/
`timescale 1ns/1ps
`default_nettype none
module trts_core_tb_top;
    import trts_pkg::*;
    `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
        $display("[FAIL] t=%0t got %0h exp %0h", $time, (g), (e)); end end
    `define WAIT(c) n = 0; while (!(c) && n < 600) begin @(posedge pclk); n++; end
    localparam logic [31:0] REQUESTED_ROTATION_TIME_V = 32'hFFFF_FF38;
    localparam logic [31:0] MAXIMUM_TIME_VALUE_V = 32'hFFFF_FE70;
    localparam int E_TOK = 0, E_TVX = 1, E_HI = 2, E_MYC = 3, E_MYB = 4, E_BCN = 5, E_MAC = 6, E_FD = 7;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} trts_reg_s;
    typedef struct packed {trts_class_e c; trts_cap_e p; logic [3:0] f; trts_mode_e m;} trts_row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, rd2;
    logic token_rcvd, token_rstr, tvx_expired, claim_higher, my_claim, my_beacon, beacon_rcvd, mac_frame_rcvd;
    logic frame_done, svc_start, token_issue, token_issue_rstr, ring_op, late_flag, recovery_req;
    logic req_valid = 1'b0, req_issue_rstr = 1'b0, req_tht_en = 1'b0, req_done = 1'b0;
    logic data_ready = 1'b0, frame_active = 1'b0;
    trts_class_e req_class = CL_SYNC;
    trts_cap_e req_capture = CP_NONE;
    trts_mode_e tx_mode;
    int mismatches = 0, samples_checked = 0, cyc = 0, n;
    // Reset values as the register table gives them; the last row is an unmapped place.
    trts_reg_s regs [7] = '{'{A_CTRL, 32'h0, 1'b0}, '{A_NEGOTIATED_TARGET_VALUE, NEGOTIATED_TARGET_VALUE_RST, 1'b0}, '{A_MAXIMUM_TIME_VALUE, MAXIMUM_TIME_VALUE_RST, 1'b0},
        '{A_REQUESTED_ROTATION_TIME, REQUESTED_ROTATION_TIME_RST, 1'b0}, '{A_ASYNC_PRIORITY_THRESHOLD, ASYNC_PRIORITY_THRESHOLD_RST, 1'b0}, '{A_STAT, 32'h0, 1'b0}, '{8'h20, 32'h0, 1'b1}};
    // Flags are token restricted, issue restricted, data ready, service expected.
    trts_row_s rows [9] = '{'{CL_ASYNC, CP_NRSTR, 4'b0011, MD_DATA}, '{CL_ASYNC, CP_NRSTR, 4'b0001, MD_VOID},
        '{CL_SYNC, CP_ANY, 4'b1011, MD_DATA}, '{CL_ASYNC, CP_RSTR, 4'b0010, MD_REPEAT},
        '{CL_APRI, CP_NRSTR, 4'b0010, MD_REPEAT}, '{CL_IMM, CP_NONE, 4'b0010, MD_REPEAT},
        '{CL_ASYNC, CP_NRSTR, 4'b0111, MD_DATA}, '{CL_ASYNC, CP_NRSTR, 4'b0110, MD_REPEAT},
        '{CL_ASYNC, CP_RSTR, 4'b1011, MD_DATA}};

    trts_core #(.TW(32)) u_trts_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .token_rcvd(token_rcvd), .token_rstr(token_rstr), .tvx_expired(tvx_expired), .claim_higher(claim_higher),
        .my_claim(my_claim), .my_beacon(my_beacon), .beacon_rcvd(beacon_rcvd), .mac_frame_rcvd(mac_frame_rcvd),
        .req_valid(req_valid), .req_class(req_class), .req_capture(req_capture), .req_issue_rstr(req_issue_rstr),
        .req_tht_en(req_tht_en), .req_done(req_done), .data_ready(data_ready), .frame_active(frame_active),
        .frame_done(frame_done), .svc_start(svc_start), .token_issue(token_issue),
        .token_issue_rstr(token_issue_rstr), .tx_mode(tx_mode), .ring_op(ring_op), .late_flag(late_flag),
        .recovery_req(recovery_req));
    trts_ring_model u_trts_ring_model (.pclk(pclk), .token_rcvd(token_rcvd), .token_rstr(token_rstr),
        .tvx_expired(tvx_expired), .claim_higher(claim_higher), .my_claim(my_claim), .my_beacon(my_beacon),
        .beacon_rcvd(beacon_rcvd), .mac_frame_rcvd(mac_frame_rcvd), .frame_done(frame_done));

    // ****************************************
    // Clock, watchdog and shared tasks
    // ****************************************
    always #50 pclk = ~pclk;

    // The whole run needs about 1200 cycles; a hang is cut off well beyond that.
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            results();
        end
    end

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // One APB transfer: setup, then access held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK(k, 1)
    endtask

    // A ring event; the registered answer is sampled at the edge after the event.
    task automatic pulse(input int k, input logic r);
        u_trts_ring_model.ev(k, r);
        @(posedge pclk);
    endtask

    // One request held until decided, a token offered (none for immediate), then closed.
    task automatic svc(input trts_class_e c, input trts_cap_e p, input logic tr, input logic ir,
                       input logic dr, input logic es, input trts_mode_e em);
        @(posedge pclk);
        req_valid <= 1'b1;
        req_class <= c;
        req_capture <= p;
        req_issue_rstr <= ir;
        data_ready <= dr;
        req_tht_en <= (c == CL_ASYNC);
        if (c == CL_IMM)
            repeat (2) @(posedge pclk);
        else
            pulse(E_TOK, tr);
        `CHK(svc_start, es)
        if (es)
        begin
            `CHK(tx_mode, em)
            if (c != CL_IMM)
            begin
                apb(1'b0, A_THT, 32'h0);
                rd2 = rd;
                apb(1'b0, A_THT, 32'h0);
                `CHK(rd != rd2, req_tht_en)
            end
            req_done <= 1'b1;
            frame_active <= 1'b1;
            pulse(E_FD, 1'b0);
            if (c != CL_IMM)
            begin
                `CHK(token_issue, 1'b1)
                `CHK(token_issue_rstr, ir)
            end
        end
        req_valid <= 1'b0;
        req_done <= 1'b0;
        frame_active <= 1'b0;
        @(posedge pclk);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i])
        begin
            apb(1'b0, regs[i].a, 32'h0);
            `CHK(rd, regs[i].d)
            `CHK(er, regs[i].e)
        end
        apb(1'b1, A_TRT, 32'h0);
        `CHK(er, 1'b1)
        $display("test registers finished");
        apb(1'b1, A_REQUESTED_ROTATION_TIME, REQUESTED_ROTATION_TIME_V);
        apb(1'b1, A_MAXIMUM_TIME_VALUE, MAXIMUM_TIME_VALUE_V);
        apb(1'b1, A_CTRL, 32'h1);
        apb(1'b0, A_TRT, 32'h0);
        `CHK((rd - MAXIMUM_TIME_VALUE_V) < 32'd8, 1'b1)
        apb(1'b1, A_CTRL, 32'h8);
        `WAIT(tx_mode === MD_BEACON)
        `CHK(tx_mode, MD_BEACON)
        pulse(E_MYB, 1'b0);
        `CHK(tx_mode, MD_CLAIM)
        pulse(E_MYC, 1'b0);
        `CHK(ring_op, 1'b1)
        apb(1'b0, A_NEGOTIATED_TARGET_VALUE, 32'h0);
        `CHK(rd, REQUESTED_ROTATION_TIME_V)
        $display("test claim finished");
        foreach (rows[i])
            svc(rows[i].c, rows[i].p, rows[i].f[3], rows[i].f[2], rows[i].f[1], rows[i].f[0], rows[i].m);
        pulse(E_BCN, 1'b0);
        svc(CL_SYNC, CP_ANY, 1'b0, 1'b0, 1'b1, 1'b0, MD_DATA);
        apb(1'b1, A_CTRL, 32'h10);
        svc(CL_SYNC, CP_ANY, 1'b0, 1'b0, 1'b1, 1'b1, MD_DATA);
        $display("test service finished");
        // Starve the ring of tokens: late, a late token, late again, then recovery.
        `WAIT(late_flag === 1'b1)
        `CHK(late_flag, 1'b1)
        pulse(E_TOK, 1'b0);
        `CHK(late_flag, 1'b0)
        `WAIT(late_flag === 1'b1)
        `WAIT(recovery_req === 1'b1)
        `CHK(recovery_req, 1'b1)
        `CHK(ring_op, 1'b0)
        apb(1'b0, A_TRT, 32'h0);
        `CHK((rd - MAXIMUM_TIME_VALUE_V) < 32'd8, 1'b1)
        `WAIT(tx_mode === MD_BEACON)
        `CHK(tx_mode, MD_BEACON)
        pulse(E_MYB, 1'b0);
        pulse(E_MYC, 1'b0);
        `CHK(ring_op, 1'b1)
        $display("test recovery finished");
        pulse(E_MAC, 1'b0);
        svc(CL_ASYNC, CP_RSTR, 1'b1, 1'b0, 1'b1, 1'b0, MD_DATA);
        pulse(E_TVX, 1'b0);
        `CHK(tx_mode, MD_CLAIM)
        pulse(E_HI, 1'b0);
        `CHK(tx_mode, MD_REPEAT)
        apb(1'b1, A_CTRL, 32'h8);
        `WAIT(tx_mode === MD_BEACON)
        svc(CL_IMM, CP_NONE, 1'b0, 1'b0, 1'b0, 1'b1, MD_BEACON);
        $display("test immediate finished");
        results();
    end
endmodule
`default_nettype wire
